// [common/pftmr_pkg.sv]
`default_nettype none
package pftmr_pkg;

  // Data path widths
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PSS_W = 11;
  localparam int unsigned PSW_W = 5;
  localparam int unsigned FXDIV_W = 3;
  localparam int unsigned OSCDIV_W = 5;
  localparam int unsigned MODE_W = 4;
  localparam int unsigned DIVSEL_W = 2;
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_MODE = 10'h008;
  localparam logic [ADDR_W-1:0] ADDR_DIVSEL = 10'h009;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 10'h00A;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 10'h00B;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 10'h00C;

  // Reset values
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [DIVSEL_W-1:0] DIVSEL_RESET = 2'h0;
  localparam logic [CNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic MASK_RESET = 1'b0;

  // Mode register fields
  localparam int unsigned MODE_SRC_BIT = 3;
  localparam logic [MODE_W-1:0] MODE_WMASK_NOSUB = 4'h7;
  localparam logic [MODE_W-1:0] MODE_WMASK_SUB = 4'hF;
  localparam logic [2:0] PSW_CLEAR_BITS = 3'h7;
  localparam logic [2:0] PSW_HALF_CODE = 3'h4;
  localparam logic [CNT_W-1:0] COUNT_MAX = 8'hFF;

  // Tap widths: a period of 2^k prescaler cycles is the rollover of the low k bits
  localparam int unsigned PSS_TAP_BITS [8] = '{11, 10, 9, 7, 5, 3, 2, 1};
  localparam int unsigned PSW_TAP_BITS [4] = '{5, 4, 3, 1};
  localparam int unsigned OSC_TAP_BITS [4] = '{2, 3, 4, 5};
  localparam int unsigned FX_TAP_BITS = 3;
  localparam int unsigned FX_HALF_BITS = 2;

endpackage
`default_nettype wire

// [common/pftmr_pre_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pftmr_pre_if #(parameter int unsigned W = 8) ();
  logic tick;
  logic clear;
  logic [W-1:0] count;
  modport ctr (input tick, input clear, output count);
  modport user (output tick, output clear, input count);
endinterface
`default_nettype wire

// [rtl/pftmr_irq.sv]
`timescale 1ns/1ps
`default_nettype none
module pftmr_irq (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Event and software side
  input wire logic evt,
  input wire logic rd_clear,
  input wire logic mask,
  // Results
  output logic status,
  output logic irq
);

  // Sticky pending flag; an event in the clearing cycle wins so none is lost
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      status <= 1'b0;
    end
    else if (clk_en)
    begin
      if (evt)
      begin
        status <= 1'b1;
      end
      else if (rd_clear)
      begin
        status <= 1'b0;
      end
    end
  end

  // Registered level output, one cycle behind the flag
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq <= status & mask;
    end
  end

endmodule // pftmr_irq
`default_nettype wire

// [rtl/pftmr_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module pftmr_prescaler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Counter carrier
  pftmr_pre_if.ctr p
);

  // Free-running up counter; clear beats count, caller gates both with the enable
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      p.count <= '0;
    end
    else if (p.clear)
    begin
      p.count <= '0;
    end
    else if (p.tick)
    begin
      p.count <= p.count + 1'b1;
    end
  end

endmodule // pftmr_prescaler
`default_nettype wire

// [rtl/pftmr_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Eight-bit up counter steps once per selected clock period, wrapping without reload.
// (R2) Overflow from maximum back to zero raises the timer interrupt request.
// (R3) Four-bit write-only mode register at 0x008; reads return zero.
// (R4) Mode register clears to zero on reset and while stop mode holds.
// (R5) System source periods 2048,1024,512,128,32,8,4,2 cycles; bit 3 ignored.
// (R6) One system prescaler cycle equals one peripheral clock period; in subactive mode the code clocks it from the subsystem clock instead.
// (R7) Subclock source and time base exist only when the subclock variant is built.
// (R8) Mode bit 3 picks the source: 0 system prescaler, 1 subclock prescaler.
// (R9) Subclock periods 32,16,8,2,1/2 cycles; 101 idle; 11x clears both counters.
// (R10) Bit 3 low is free-running mode, high is clock time base mode.
// (R11) One subclock prescaler cycle is the subsystem clock divided by eight.
// (R12) Eleven-bit system prescaler, reset clear, halts in stop and watch modes; the code halts it in watch only in the subclock variant.
// (R13) Five-bit subclock prescaler on subclock over eight, halts only in stop.
// (R14) Writing ones to mode bits 3 to 1 clears the subclock prescaler.
// (R15) Subclock variant scales peripheral clock by 4, 8, 16 or 32 by divider select.
// (R16) Counter resets to zero and keeps its value across clock selection changes.
// (R17) Overflow latches a pending flag that software reads and clears.
module pftmr_top #(
  parameter bit HAS_SUBCLK = 1'b1
) (
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [pftmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pftmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pftmr_pkg::DATA_W-1:0] reg_rdata,
  // Power modes and subsystem oscillator
  input wire logic stop_mode,
  input wire logic watch_mode,
  input wire logic subactive_mode,
  input wire logic sub_osc_tick,
  // Results
  output logic irq,
  output logic [pftmr_pkg::CNT_W-1:0] timer_count_value
);

  // Registers and internal state
  logic [pftmr_pkg::MODE_W-1:0] timer_clock_mode_q;
  logic [pftmr_pkg::DIVSEL_W-1:0] sysclk_divider_select_q;
  logic [pftmr_pkg::CNT_W-1:0] count_q;
  logic irq_mask_q;
  logic irq_status;
  logic [pftmr_pkg::DATA_W-1:0] rdata_q;

  // Decoded strobes and ticks
  logic wr_mode;
  logic wr_divsel;
  logic wr_mask;
  logic rd_status;
  logic clear_cmd;
  logic src_sub;
  logic per_tick;
  logic fx_tick;
  logic w_tick;
  logic w_half_tick;
  logic pss_in;
  logic pss_run;
  logic pss_tick;
  logic pss_sel;
  logic psw_sel;
  logic count_tick;
  logic overflow;
  logic [1:0] osc_code;

  // Prescaler carriers
  pftmr_pre_if #(.W(pftmr_pkg::OSCDIV_W)) osc_if ();
  pftmr_pre_if #(.W(pftmr_pkg::FXDIV_W)) fx_if ();
  pftmr_pre_if #(.W(pftmr_pkg::PSS_W)) pss_if ();
  pftmr_pre_if #(.W(pftmr_pkg::PSW_W)) psw_if ();

  // True when the low k bits of a prescaler count are all ones
  function automatic logic tap_hit(input logic [pftmr_pkg::PSS_W-1:0] cnt,
                                   input int unsigned k);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < pftmr_pkg::PSS_W; i++)
    begin
      if ((i < k) && !cnt[i])
      begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction

  // Register port decode; every strobe is frozen with the clock enable
  always_comb
  begin
    wr_mode = clk_en && reg_wr && (reg_addr == pftmr_pkg::ADDR_MODE);
    wr_divsel = clk_en && reg_wr && (reg_addr == pftmr_pkg::ADDR_DIVSEL);
    wr_mask = clk_en && reg_wr && (reg_addr == pftmr_pkg::ADDR_IRQ_MASK);
    rd_status = clk_en && reg_rd && (reg_addr == pftmr_pkg::ADDR_IRQ_STATUS);
  end

  // Clear command exists only when the subclock source is built
  always_comb
  begin
    clear_cmd = HAS_SUBCLK && wr_mode
                && (reg_wdata[pftmr_pkg::MODE_SRC_BIT:1] == pftmr_pkg::PSW_CLEAR_BITS); // (R14)
    src_sub = HAS_SUBCLK && timer_clock_mode_q[pftmr_pkg::MODE_SRC_BIT]; // (R7)
  end

  // Mode register; stop mode dominates a write in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      timer_clock_mode_q <= pftmr_pkg::MODE_RESET; // (R4)
    end
    else if (clk_en)
    begin
      if (stop_mode)
      begin
        timer_clock_mode_q <= pftmr_pkg::MODE_RESET; // (R4)
      end
      else if (wr_mode)
      begin
        // Bit 3 is not stored without the subclock source, so it can never steer
        timer_clock_mode_q <= reg_wdata[pftmr_pkg::MODE_W-1:0]
                              & (HAS_SUBCLK ? pftmr_pkg::MODE_WMASK_SUB
                                            : pftmr_pkg::MODE_WMASK_NOSUB); // (R3) (R5)
      end
    end
  end

  // Oscillator divisor select, meaningful only in the subclock variant
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sysclk_divider_select_q <= pftmr_pkg::DIVSEL_RESET;
    end
    else if (wr_divsel)
    begin
      sysclk_divider_select_q <= reg_wdata[pftmr_pkg::DIVSEL_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_mask_q <= pftmr_pkg::MASK_RESET;
    end
    else if (wr_mask)
    begin
      irq_mask_q <= reg_wdata[0];
    end
  end

  // Peripheral clock from the oscillator; fixed divide by four without subclock
  always_comb
  begin
    osc_code = HAS_SUBCLK ? sysclk_divider_select_q : pftmr_pkg::DIVSEL_RESET; // (R15)
    osc_if.tick = clk_en;
    osc_if.clear = 1'b0;
    per_tick = clk_en && tap_hit(pftmr_pkg::PSS_W'(osc_if.count),
                                 pftmr_pkg::OSC_TAP_BITS[osc_code]); // (R15) (R6)
  end

  pftmr_prescaler u_osc_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .p(osc_if)
  );

  // Subsystem clock over eight; the oscillator is stopped in stop mode
  always_comb
  begin
    fx_tick = clk_en && sub_osc_tick && !stop_mode;
    fx_if.tick = fx_tick;
    fx_if.clear = 1'b0;
    w_tick = fx_tick && tap_hit(pftmr_pkg::PSS_W'(fx_if.count), pftmr_pkg::FX_TAP_BITS); // (R11)
    // Half a subclock prescaler cycle comes from the divider's second bit
    w_half_tick = fx_tick && tap_hit(pftmr_pkg::PSS_W'(fx_if.count), pftmr_pkg::FX_HALF_BITS);
  end

  pftmr_prescaler u_fx_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .p(fx_if)
  );

  // System prescaler: subsystem clock in subactive mode, halted in stop and watch
  always_comb
  begin
    pss_in = (HAS_SUBCLK && subactive_mode) ? fx_tick : per_tick; // (R12)
    pss_run = !stop_mode && !(HAS_SUBCLK && watch_mode); // (R12)
    pss_tick = clk_en && pss_run && pss_in;
    pss_if.tick = pss_tick; // (R6)
    pss_if.clear = 1'b0;
  end

  pftmr_prescaler u_pss (
    .clk_sys(clk_sys),
    .rst(rst),
    .p(pss_if)
  );

  // Subclock prescaler, absent without the subclock variant
  always_comb
  begin
    psw_if.tick = HAS_SUBCLK && w_tick; // (R13) (R7)
    psw_if.clear = clear_cmd; // (R14)
  end

  pftmr_prescaler u_psw (
    .clk_sys(clk_sys),
    .rst(rst),
    .p(psw_if)
  );

  // Free-running source: rollover of the tap picked by the period select
  always_comb
  begin
    pss_sel = pss_tick
              && tap_hit(pss_if.count,
                         pftmr_pkg::PSS_TAP_BITS[timer_clock_mode_q[2:0]]); // (R5)
  end

  // Time base source; code 101 gives no count and 11x only clears
  always_comb
  begin
    psw_sel = 1'b0;
    unique case (timer_clock_mode_q[2:0])
      3'h0, 3'h1, 3'h2, 3'h3:
      begin
        psw_sel = psw_if.tick
                  && tap_hit(pftmr_pkg::PSS_W'(psw_if.count),
                             pftmr_pkg::PSW_TAP_BITS[timer_clock_mode_q[1:0]]); // (R9)
      end
      pftmr_pkg::PSW_HALF_CODE:
      begin
        psw_sel = HAS_SUBCLK && w_half_tick; // (R9)
      end
      3'h5, 3'h6, 3'h7:
      begin
        psw_sel = 1'b0; // (R9)
      end
    endcase
  end

  // Source select; the mode change only switches the tick, not the count
  always_comb
  begin
    count_tick = src_sub ? psw_sel : pss_sel; // (R8) (R10)
    overflow = count_tick && (count_q == pftmr_pkg::COUNT_MAX) && !clear_cmd; // (R2)
  end

  // Timer count; the clear command outranks a coincident tick
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      count_q <= pftmr_pkg::COUNT_RESET; // (R16)
    end
    else if (clk_en)
    begin
      if (clear_cmd)
      begin
        count_q <= pftmr_pkg::COUNT_RESET; // (R9)
      end
      else if (count_tick)
      begin
        count_q <= count_q + 1'b1; // (R1) (R16)
      end
    end
  end

  // Overflow pending flag and masked interrupt
  pftmr_irq u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .evt(overflow), // (R2) (R17)
    .rd_clear(rd_status), // (R17)
    .mask(irq_mask_q),
    .status(irq_status),
    .irq(irq)
  );

  // Read data stands only in the cycle after the strobe; mode reads as zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= '0;
    end
    else if (clk_en)
    begin
      rdata_q <= '0;
      if (reg_rd)
      begin
        unique case (reg_addr)
          pftmr_pkg::ADDR_IRQ_STATUS: rdata_q <= pftmr_pkg::DATA_W'(irq_status); // (R17)
          pftmr_pkg::ADDR_IRQ_MASK: rdata_q <= pftmr_pkg::DATA_W'(irq_mask_q);
          pftmr_pkg::ADDR_COUNT: rdata_q <= count_q;
          pftmr_pkg::ADDR_DIVSEL: rdata_q <= pftmr_pkg::DATA_W'(sysclk_divider_select_q);
          pftmr_pkg::ADDR_MODE: rdata_q <= '0; // (R3)
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // Outputs straight from flops
  always_comb
  begin
    reg_rdata = rdata_q;
    timer_count_value = count_q;
  end

endmodule // pftmr_top
`default_nettype wire

// [tb/pftmr_top_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module pftmr_top_properties (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire logic [pftmr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pftmr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pftmr_pkg::DATA_W-1:0] reg_rdata,
  // Power mode and results
  input wire logic stop_mode,
  input wire logic irq,
  input wire logic [pftmr_pkg::CNT_W-1:0] timer_count_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic mask_q;
  // Shadow of the interrupt mask, so irq can be judged from the ports alone
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      mask_q <= 1'b0;
    else if (clk_en && reg_wr && reg_addr == pftmr_pkg::ADDR_IRQ_MASK)
      mask_q <= reg_wdata[0];
  // Count only holds, steps by one, or is cleared
  a_count_step: assert property (
    1'b1 |=> timer_count_value == $past(timer_count_value) || timer_count_value == 8'h00
      || timer_count_value == $past(timer_count_value) + 8'h01) else $error("count jumped");
  a_mode_wo: assert property (
    clk_en && reg_rd && reg_addr == pftmr_pkg::ADDR_MODE |=> reg_rdata == 8'h00)
    else $error("mode register readable");
  a_wrap_irq: assert property (
    (timer_count_value == 8'hFF && clk_en && !reg_wr) ##1 (timer_count_value == 8'h00
      && clk_en && mask_q) |=> irq) else $error("overflow without irq");
  a_irq_masked: assert property (
    clk_en && !mask_q |=> !irq) else $error("masked irq raised");
  a_reset_clear: assert property (
    $fell(rst) |-> timer_count_value == 8'h00 && !irq && reg_rdata == 8'h00)
    else $error("state not cleared by reset");
  a_stop_hold: assert property (
    (stop_mode && clk_en) [*3] |-> $stable(timer_count_value)) else $error("count ran in stop");
  a_enable_freeze: assert property (
    !clk_en |=> $stable(timer_count_value) && $stable(irq) && $stable(reg_rdata))
    else $error("state moved without enable");
  // Ones in mode bits 3 to 1 clear the count, and it stays clear
  a_clear_code: assert property (
    clk_en && reg_wr && reg_addr == pftmr_pkg::ADDR_MODE && reg_wdata[3:1] == 3'h7
      && !stop_mode |=> ##1 (timer_count_value == 8'h00) [*4]) else $error("clear code failed");
endmodule // pftmr_top_properties
bind pftmr_top pftmr_top_properties u_props (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .stop_mode(stop_mode), .irq(irq),
  .timer_count_value(timer_count_value));
`default_nettype wire

// [tb/tb_prescaled_free_running_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_prescaled_free_running_timer;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [pftmr_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [pftmr_pkg::DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic stop_mode = 1'b0;
  logic watch_mode = 1'b0;
  logic subactive_mode = 1'b0;
  logic sub_osc_tick = 1'b0;
  logic [2:0] sub_div = '0;
  logic [pftmr_pkg::DATA_W-1:0] reg_rdata;
  logic irq;
  logic [pftmr_pkg::CNT_W-1:0] timer_count_value;
  int n_fail = 0;
  int cmp_count = 0;
  int per [8] = '{2048, 1024, 512, 128, 32, 8, 4, 2};
  int pw [4] = '{32, 16, 8, 2};
  pftmr_top u_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .watch_mode(watch_mode), .subactive_mode(subactive_mode),
    .sub_osc_tick(sub_osc_tick), .irq(irq), .timer_count_value(timer_count_value));
  // System clock
  initial forever #5 clk_sys = ~clk_sys;
  // Subsystem pulse every fifth clock, so its rates never alias the /4 peripheral tick
  always @(posedge clk_sys)
  begin
    sub_div <= (sub_div == 3'h4) ? 3'h0 : sub_div + 3'h1;
    sub_osc_tick <= (sub_div == 3'h4);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Bus cycles: one-cycle strobes, read data taken in the cycle after the strobe
  task automatic wr(input logic [pftmr_pkg::ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [pftmr_pkg::ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  // Cycles until the count next changes; a stuck count ends at the bound
  task automatic wstep(output int n);
    logic [7:0] c;
    c = timer_count_value;
    n = 0;
    while (timer_count_value === c && n < 20000)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rate(input logic [3:0] m, input logic [1:0] d, input logic sa, input int e);
    int n;
    logic [7:0] c;
    @(posedge clk_sys);
    subactive_mode <= sa;
    wr(pftmr_pkg::ADDR_DIVSEL, {6'h00, d});
    wr(pftmr_pkg::ADDR_MODE, {4'h0, m});
    wstep(n);
    c = timer_count_value;
    wstep(n);
    chk(n, e);
    chk(timer_count_value, c + 8'h01);
  endtask
  task automatic t_reset;
    logic [7:0] d;
    chk(timer_count_value, 8'h00);
    chk(irq, 1'b0);
    rd(pftmr_pkg::ADDR_MODE, d);
    chk(d, 8'h00);
    wr(pftmr_pkg::ADDR_MODE, 8'h07);
    rd(pftmr_pkg::ADDR_MODE, d);
    chk(d, 8'h00);
    rd(10'h3FF, d);
    chk(d, 8'h00);
    wr(pftmr_pkg::ADDR_DIVSEL, 8'h03);
    rd(pftmr_pkg::ADDR_DIVSEL, d);
    chk(d, 8'h03);
  endtask
  // Every period code of both sources, every divider code, and the subactive source
  task automatic t_rates;
    for (int i = 0; i < 8; i++) rate(i[3:0], 2'h0, 1'b0, 4 * per[i]);
    rate(4'h6, 2'h1, 1'b0, 32);
    rate(4'h7, 2'h2, 1'b0, 32);
    rate(4'h7, 2'h3, 1'b0, 64);
    rate(4'h7, 2'h0, 1'b1, 10);
    for (int j = 0; j < 4; j++) rate(4'h8 + j[3:0], 2'h0, 1'b0, 40 * pw[j]);
    rate(4'hC, 2'h0, 1'b0, 20);
  endtask
  task automatic t_clear;
    logic [7:0] c;
    for (int k = 14; k < 16; k++)
    begin
      wr(pftmr_pkg::ADDR_MODE, 8'h07);
      cyc(40);
      wr(pftmr_pkg::ADDR_MODE, k[7:0]);
      cyc(40);
      chk(timer_count_value, 8'h00);
    end
    wr(pftmr_pkg::ADDR_MODE, 8'h07);
    cyc(40);
    wr(pftmr_pkg::ADDR_MODE, 8'h0D);
    cyc(2);
    c = timer_count_value;
    cyc(60);
    chk(timer_count_value, c);
  endtask
  task automatic hold(output logic [7:0] c);
    cyc(2);
    c = timer_count_value;
    cyc(30);
  endtask
  // Stop clears the mode, so the slowest period follows; watch and enable only freeze
  task automatic t_stop;
    logic [7:0] c;
    int n;
    wr(pftmr_pkg::ADDR_MODE, 8'h07);
    @(posedge clk_sys);
    stop_mode <= 1'b1;
    hold(c);
    chk(timer_count_value, c);
    @(posedge clk_sys);
    stop_mode <= 1'b0;
    wstep(n);
    wstep(n);
    chk(n, 8192);
    wr(pftmr_pkg::ADDR_MODE, 8'h07);
    @(posedge clk_sys);
    watch_mode <= 1'b1;
    hold(c);
    chk(timer_count_value, c);
    @(posedge clk_sys);
    watch_mode <= 1'b0;
    clk_en <= 1'b0;
    hold(c);
    chk(timer_count_value, c);
    @(posedge clk_sys);
    clk_en <= 1'b1;
  endtask
  task automatic t_irq;
    logic [7:0] d;
    int n;
    wr(pftmr_pkg::ADDR_MODE, 8'h07);
    for (int k = 1; k >= 0; k--)
    begin
      wr(pftmr_pkg::ADDR_IRQ_MASK, k[7:0]);
      rd(pftmr_pkg::ADDR_IRQ_MASK, d);
      chk(d, k);
      rd(pftmr_pkg::ADDR_IRQ_STATUS, d);
      n = 0;
      while (timer_count_value !== 8'hFF && n < 3000)
      begin
        cyc(1);
        n++;
      end
      wstep(n);
      chk(timer_count_value, 8'h00);
      cyc(2);
      chk(irq, k[0]);
      rd(pftmr_pkg::ADDR_IRQ_STATUS, d);
      chk(d, 8'h01);
      rd(pftmr_pkg::ADDR_IRQ_STATUS, d);
      chk(d, 8'h00);
      chk(irq, 1'b0);
    end
  endtask
  task automatic end_of_test;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    t_reset;
    t_rates;
    t_clear;
    t_stop;
    t_irq;
    end_of_test;
  end
  // Watchdog, beyond the roughly fifty-four thousand cycles the run needs but under the run limit
  initial
  begin
    #(90000 * 10);
    n_fail++;
    end_of_test;
  end
endmodule // tb_prescaled_free_running_timer
`default_nettype wire
